// ---- dspl_pkg.sv ----
package dspl_pkg;

  localparam int          DATA_W        = 8;
  localparam int          OFF_W         = 5;
  localparam int          IDX_W         = 4;
  localparam int          REG_COUNT     = 32;

  // Command codes
  localparam logic [7:0]  CMD_BASE_CFG  = 8'h40;
  localparam logic [7:0]  CMD_BLOCKS    = 8'h44;
  localparam logic [7:0]  CMD_FINE_SHIFT = 8'h5A;
  localparam logic [7:0]  CMD_COMBINE   = 8'h5B;

  // Parameter counts per command, index limit and base setup skip
  localparam logic [3:0]  BASE_CFG_LEN  = 4'h8;
  localparam logic [3:0]  BLOCKS_LEN    = 4'hA;
  localparam logic [3:0]  SINGLE_LEN    = 4'h1;
  localparam logic [3:0]  IDX_MAX       = 4'hF;
  localparam logic [3:0]  BASE_CFG_SKIP = 4'h2;

  // Register offsets
  localparam logic [4:0]  OFF_BASE_CFG  = 5'h00;
  localparam logic [4:0]  OFF_CELL_H    = 5'h02;
  localparam logic [4:0]  OFF_LINE_DISP = 5'h03;
  localparam logic [4:0]  OFF_LINE_TOT  = 5'h04;
  localparam logic [4:0]  OFF_FRAME     = 5'h05;
  localparam logic [4:0]  OFF_VW_LO     = 5'h06;
  localparam logic [4:0]  OFF_VW_HI     = 5'h07;
  localparam logic [4:0]  OFF_B1_LO     = 5'h0B;
  localparam logic [4:0]  OFF_B1_HI     = 5'h0C;
  localparam logic [4:0]  OFF_B1_LINES  = 5'h0D;
  localparam logic [4:0]  OFF_B2_LO     = 5'h0E;
  localparam logic [4:0]  OFF_B2_HI     = 5'h0F;
  localparam logic [4:0]  OFF_B2_LINES  = 5'h10;
  localparam logic [4:0]  OFF_B3_LO     = 5'h11;
  localparam logic [4:0]  OFF_B3_HI     = 5'h12;
  localparam logic [4:0]  OFF_B4_LO     = 5'h13;
  localparam logic [4:0]  OFF_B4_HI     = 5'h14;
  localparam logic [4:0]  OFF_COMBINE   = 5'h18;
  localparam logic [4:0]  OFF_SHIFT     = 5'h1B;

  // Field masks and reset value
  localparam logic [7:0]  MASK_FULL     = 8'hFF;
  localparam logic [7:0]  MASK_CELL_H   = 8'h0F;
  localparam logic [7:0]  MASK_COMBINE  = 8'h0F;
  localparam logic [7:0]  MASK_SHIFT    = 8'h07;
  localparam logic [7:0]  REG_RESET     = 8'h00;

  // Field positions in the combine register
  localparam int          BIT_MODE_LO   = 0;
  localparam int          BIT_MODE_HI   = 1;
  localparam int          BIT_B1_SEL    = 2;
  localparam int          BIT_B3_SEL    = 3;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_BASE    = 5'b00010,
    ST_BLOCKS  = 5'b00100,
    ST_SHIFT   = 5'b01000,
    ST_COMBINE = 5'b10000
  } dspl_state_t;

  typedef struct packed {
    logic        wr;
    logic        cmd_select_line;
    logic [7:0]  data;
  } dspl_host_t;

  typedef struct packed {
    logic [3:0]  char_cell_height;
    logic [7:0]  line_display_addresses;
    logic [7:0]  line_total_addresses;
    logic [7:0]  frame_line_count;
    logic [15:0] virtual_width;
    logic [15:0] block1_start;
    logic [7:0]  block1_line_count;
    logic [15:0] block2_start;
    logic [7:0]  block2_line_count;
    logic [15:0] block3_start;
    logic [15:0] block4_start;
    logic        combine_mode_hi;
    logic        combine_mode_lo;
    logic        block1_text_select;
    logic        block3_text_select;
    logic [2:0]  fine_pixel_shift;
  } dspl_cfg_t;

  typedef struct packed {
    logic [4:0]  cell_height_px;
    logic [8:0]  line_display_count;
    logic [8:0]  line_total_count;
    logic [8:0]  frame_lines;
  } dspl_eff_t;

endpackage : dspl_pkg

// ---- dspl_param_loader.sv ----
// Operation
// - Write with select line high is a command; low is a parameter byte.
// - Size and count fields hold quantity minus one; effective value adds one. The code forms effective values only for 02h to 05h.
// - Base setup third parameter: cell height minus one into 02h bits 3-0.
// - Base setup fourth parameter: displayed addresses per line minus one into 03h.
// - Base setup fifth parameter: total addresses per line minus one into 04h.
// - Base setup sixth parameter: display lines per frame minus one into 05h.
// - Base setup seventh and eighth: virtual width low 06h, high 07h.
// - Command 44h first two parameters: block 1 start, low 0Bh, high 0Ch.
// - Block setup third parameter: block 1 line count into 0Dh.
// - Block setup fourth and fifth: block 2 start, low 0Eh, high 0Fh.
// - Block setup sixth parameter: block 2 line count into 10h.
// - Block setup seventh and eighth: block 3 start, low 11h, high 12h.
// - Block setup ninth and tenth: block 4 start, low 13h, high 14h.
// - Command 5Ah parameter sets fine pixel shift in 1Bh bits 2-0.
// - Command 5Bh parameter bits 1-0 set combine mode in 18h.
// - Register 18h bit 2 picks block 1 text or graphics; zero is text.
// - Register 18h bit 3 picks block 3 text or graphics; zero is text.
`timescale 1ns/1ps
`default_nettype none

module dspl_param_loader
  import dspl_pkg::*;
#(
  parameter int NUM_REGS = REG_COUNT
) (
  input  wire logic                   CLOCK,
  input  wire logic                   RESETN,
  input  wire dspl_pkg::dspl_host_t   HOST,
  output var  dspl_pkg::dspl_cfg_t    CFG,
  output var  dspl_pkg::dspl_eff_t    EFF,
  output var  dspl_pkg::dspl_state_t  ACTIVE_CMD,
  output var  logic [3:0]             PARAM_INDEX,
  output var  logic                   BLOCK1_GRAPHICS,
  output var  logic                   BLOCK3_GRAPHICS
);

  import dspl_pkg::*;

  // Maps command state and index to a register slot
  function automatic logic [OFF_W:0] slot_of(
    input dspl_state_t st,
    input logic [IDX_W-1:0] idx
  );
    logic [OFF_W:0] res;
    res = '0;
    case (st)
      ST_BASE: begin
        if (idx >= BASE_CFG_SKIP && idx < BASE_CFG_LEN) begin
          res = {1'b1, OFF_BASE_CFG + {1'b0, idx}};
        end
      end
      ST_BLOCKS: begin
        if (idx < BLOCKS_LEN) begin
          res = {1'b1, OFF_B1_LO + {1'b0, idx}};
        end
      end
      ST_SHIFT: begin
        if (idx < SINGLE_LEN) begin
          res = {1'b1, OFF_SHIFT};
        end
      end
      ST_COMBINE: begin
        if (idx < SINGLE_LEN) begin
          res = {1'b1, OFF_COMBINE};
        end
      end
      default: begin
        res = '0;
      end
    endcase
    return res;
  endfunction : slot_of

  // Bits kept for each slot
  function automatic logic [DATA_W-1:0] mask_of(input logic [OFF_W-1:0] off);
    logic [DATA_W-1:0] m;
    m = MASK_FULL;
    if (off == OFF_CELL_H) begin
      m = MASK_CELL_H;
    end else if (off == OFF_SHIFT) begin
      m = MASK_SHIFT;
    end else if (off == OFF_COMBINE) begin
      m = MASK_COMBINE;
    end
    return m;
  endfunction : mask_of

  dspl_state_t       state_r;
  dspl_state_t       state_nxt;
  logic [IDX_W-1:0]  idx_r;
  logic [IDX_W-1:0]  idx_nxt;
  logic [DATA_W-1:0] regs_r [NUM_REGS];
  dspl_eff_t         eff_r;
  dspl_eff_t         eff_nxt;
  logic              b1_gfx_r;
  logic              b3_gfx_r;

  // Host write decode
  wire               cmd_wr   = HOST.wr && HOST.cmd_select_line;
  wire               param_wr = HOST.wr && !HOST.cmd_select_line;
  wire [OFF_W:0]     slot     = slot_of(state_r, idx_r);
  wire               slot_hit = param_wr && slot[OFF_W];
  wire [OFF_W-1:0]   slot_off = slot[OFF_W-1:0];
  wire [DATA_W-1:0]  wr_byte  = HOST.data & mask_of(slot_off);

  // Command decode
  always_comb begin
    state_nxt = state_r;
    if (cmd_wr) begin
      case (HOST.data)
        CMD_BASE_CFG:   state_nxt = ST_BASE;
        CMD_BLOCKS:     state_nxt = ST_BLOCKS;
        CMD_FINE_SHIFT: state_nxt = ST_SHIFT;
        CMD_COMBINE:    state_nxt = ST_COMBINE;
        default:        state_nxt = ST_IDLE;
      endcase
    end
  end

  // Parameter index, saturating
  always_comb begin
    idx_nxt = idx_r;
    if (cmd_wr) begin
      idx_nxt = '0;
    end else if (param_wr && idx_r != IDX_MAX) begin
      idx_nxt = idx_r + 4'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
      idx_r   <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
    end
  end

  // Register storage
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_regs
      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          regs_r[g] <= REG_RESET;
        end else if (slot_hit && slot_off == OFF_W'(g)) begin
          regs_r[g] <= wr_byte;
        end
      end
    end
  endgenerate

  // Effective quantities, one cycle behind storage
  always_comb begin
    eff_nxt.cell_height_px     = {1'b0, regs_r[OFF_CELL_H][3:0]} + 5'h01;
    eff_nxt.line_display_count = {1'b0, regs_r[OFF_LINE_DISP]} + 9'h001;
    eff_nxt.line_total_count   = {1'b0, regs_r[OFF_LINE_TOT]} + 9'h001;
    eff_nxt.frame_lines        = {1'b0, regs_r[OFF_FRAME]} + 9'h001;
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      eff_r    <= '0;
      b1_gfx_r <= 1'b0;
      b3_gfx_r <= 1'b0;
    end else begin
      eff_r    <= eff_nxt;
      b1_gfx_r <= regs_r[OFF_COMBINE][BIT_B1_SEL];
      b3_gfx_r <= regs_r[OFF_COMBINE][BIT_B3_SEL];
    end
  end

  // Outputs from flops; CFG straight from storage, EFF and graphics flags one cycle behind it
  assign CFG.char_cell_height       = regs_r[OFF_CELL_H][3:0];
  assign CFG.line_display_addresses = regs_r[OFF_LINE_DISP];
  assign CFG.line_total_addresses   = regs_r[OFF_LINE_TOT];
  assign CFG.frame_line_count       = regs_r[OFF_FRAME];
  assign CFG.virtual_width          = {regs_r[OFF_VW_HI], regs_r[OFF_VW_LO]};
  assign CFG.block1_start           = {regs_r[OFF_B1_HI], regs_r[OFF_B1_LO]};
  assign CFG.block1_line_count      = regs_r[OFF_B1_LINES];
  assign CFG.block2_start           = {regs_r[OFF_B2_HI], regs_r[OFF_B2_LO]};
  assign CFG.block2_line_count      = regs_r[OFF_B2_LINES];
  assign CFG.block3_start           = {regs_r[OFF_B3_HI], regs_r[OFF_B3_LO]};
  assign CFG.block4_start           = {regs_r[OFF_B4_HI], regs_r[OFF_B4_LO]};
  assign CFG.combine_mode_hi        = regs_r[OFF_COMBINE][BIT_MODE_HI];
  assign CFG.combine_mode_lo        = regs_r[OFF_COMBINE][BIT_MODE_LO];
  assign CFG.block1_text_select     = regs_r[OFF_COMBINE][BIT_B1_SEL];
  assign CFG.block3_text_select     = regs_r[OFF_COMBINE][BIT_B3_SEL];
  assign CFG.fine_pixel_shift       = regs_r[OFF_SHIFT][2:0];
  assign EFF                        = eff_r;
  assign ACTIVE_CMD                 = state_r;
  assign PARAM_INDEX                = idx_r;
  assign BLOCK1_GRAPHICS            = b1_gfx_r;
  assign BLOCK3_GRAPHICS            = b3_gfx_r;

endmodule : dspl_param_loader

`default_nettype wire

// ---- dspl_param_loader_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module dspl_param_loader_checker #(
  parameter int NUM_REGS = 32
) (
  input wire logic                  CLOCK,
  input wire logic                  RESETN,
  input wire dspl_pkg::dspl_host_t  HOST,
  input wire dspl_pkg::dspl_cfg_t   CFG,
  input wire dspl_pkg::dspl_eff_t   EFF,
  input wire dspl_pkg::dspl_state_t ACTIVE_CMD,
  input wire logic [3:0]            PARAM_INDEX,
  input wire logic                  BLOCK1_GRAPHICS,
  input wire logic                  BLOCK3_GRAPHICS
);
  import dspl_pkg::*;
  wire logic prm = HOST.wr && !HOST.cmd_select_line;
  wire logic p0  = prm && PARAM_INDEX == 4'h0;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  chk_eff_height: assert property ($past(RESETN) |->
    EFF.cell_height_px == {1'b0, $past(CFG.char_cell_height)} + 5'h01) else $error("height");
  chk_eff_lines: assert property ($past(RESETN) |->
    EFF.line_display_count == {1'b0, $past(CFG.line_display_addresses)} + 9'h001
    && EFF.frame_lines == {1'b0, $past(CFG.frame_line_count)} + 9'h001) else $error("lines");
  chk_graph_copy: assert property ($past(RESETN) |->
    BLOCK1_GRAPHICS == $past(CFG.block1_text_select)
    && BLOCK3_GRAPHICS == $past(CFG.block3_text_select)) else $error("graphics");
  chk_cmd_restart: assert property (HOST.wr && HOST.cmd_select_line
    |=> PARAM_INDEX == 4'h0) else $error("restart");
  chk_index_step: assert property (prm |=> PARAM_INDEX ==
    ($past(PARAM_INDEX) == IDX_MAX ? IDX_MAX : $past(PARAM_INDEX) + 4'h1)) else $error("step");
  chk_blocks_state: assert property (HOST.wr && HOST.cmd_select_line
    && HOST.data == CMD_BLOCKS |=> ACTIVE_CMD == ST_BLOCKS) else $error("state");
  chk_shift_load: assert property (ACTIVE_CMD == ST_SHIFT && p0
    |=> CFG.fine_pixel_shift == $past(HOST.data[2:0])) else $error("shift");
  chk_idle_hold: assert property (!HOST.wr |=> $stable(CFG)) else $error("hold");
  cover property (ACTIVE_CMD == ST_BASE && p0);
  cover property (ACTIVE_CMD == ST_COMBINE && p0);
  cover property (ACTIVE_CMD == ST_BLOCKS && PARAM_INDEX == 4'hA && prm);
endmodule : dspl_param_loader_checker
bind dspl_param_loader dspl_param_loader_checker #(.NUM_REGS(NUM_REGS)) u_chk (
  .CLOCK(CLOCK), .RESETN(RESETN), .HOST(HOST), .CFG(CFG), .EFF(EFF),
  .ACTIVE_CMD(ACTIVE_CMD), .PARAM_INDEX(PARAM_INDEX),
  .BLOCK1_GRAPHICS(BLOCK1_GRAPHICS), .BLOCK3_GRAPHICS(BLOCK3_GRAPHICS));
`default_nettype wire

// ---- dspl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dspl_host_model (
  input wire logic                CLOCK,
  output var dspl_pkg::dspl_host_t HOST
);
  import dspl_pkg::*;
  initial HOST = '{wr: 1'b0, cmd_select_line: 1'b0, data: 8'h00};
  // One byte per cycle, held up to the taking edge
  task put(input logic s, input logic [7:0] d);
    @(negedge CLOCK);
    HOST = '{wr: 1'b1, cmd_select_line: s, data: d};
  endtask : put
  // Released bus shows inverted data
  task idle();
    @(negedge CLOCK);
    HOST = '{wr: 1'b0, cmd_select_line: HOST.cmd_select_line, data: ~HOST.data};
  endtask : idle
endmodule : dspl_host_model
`default_nettype wire

// ---- tb_dspl_param_loader.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_dspl_param_loader;
  import dspl_pkg::*;
  logic        clock;
  logic        resetn;
  dspl_host_t  host;
  dspl_cfg_t   cfg;
  dspl_eff_t   eff;
  dspl_state_t act;
  logic [3:0]  idx;
  logic        g1;
  logic        g3;
  int          mismatches;
  int          comparisons;
  dspl_param_loader u_dspl_param_loader (.CLOCK(clock), .RESETN(resetn), .HOST(host),
    .CFG(cfg), .EFF(eff), .ACTIVE_CMD(act), .PARAM_INDEX(idx),
    .BLOCK1_GRAPHICS(g1), .BLOCK3_GRAPHICS(g3));
  dspl_host_model u_host (.CLOCK(clock), .HOST(host));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task seq(input logic [7:0] c, input logic [7:0] p[$]);
    u_host.put(1'b1, c);
    foreach (p[i]) u_host.put(1'b0, p[i]);
    u_host.idle();
    u_host.idle();
  endtask : seq
  task t_base();
    seq(CMD_BASE_CFG, {8'h38, 8'h87, 8'h07, 8'h3F, 8'h49, 8'h7F, 8'h80, 8'h00});
    chk(cfg.char_cell_height, 16'h0007);
    chk(eff.cell_height_px, 16'h0008);
    chk(cfg.line_display_addresses, 16'h003F);
    chk(eff.line_display_count, 16'h0040);
    chk(cfg.line_total_addresses, 16'h0049);
    chk(eff.line_total_count, 16'h004A);
    chk(cfg.frame_line_count, 16'h007F);
    chk(eff.frame_lines, 16'h0080);
    chk(cfg.virtual_width, 16'h0080);
    $display("base setup done");
  endtask : t_base
  task t_blocks();
    seq(CMD_BLOCKS, {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'hEE});
    chk(cfg.block1_start, 16'h0201);
    chk(cfg.block1_line_count, 16'h0003);
    chk(cfg.block2_start, 16'h0504);
    chk(cfg.block2_line_count, 16'h0006);
    chk(cfg.block3_start, 16'h0807);
    chk(cfg.block4_start, 16'h0A09);
    chk(idx, 16'h000B);
    seq(CMD_BLOCKS, {8'hCD});
    chk(cfg.block1_start, 16'h02CD);
    chk(cfg.char_cell_height, 16'h0007);
    $display("block setup done");
  endtask : t_blocks
  task t_mode();
    seq(CMD_FINE_SHIFT, {8'hFD});
    chk(cfg.fine_pixel_shift, 16'h0005);
    seq(8'h99, {8'h02});
    chk(act, ST_IDLE);
    chk(cfg.fine_pixel_shift, 16'h0005);
    seq(CMD_COMBINE, {8'hFD});
    chk({cfg.combine_mode_hi, cfg.combine_mode_lo}, 16'h0001);
    chk({g3, g1}, 16'h0003);
    for (int m = 0; m < 4; m++) begin
      seq(CMD_COMBINE, {8'(m)});
      chk({cfg.combine_mode_hi, cfg.combine_mode_lo}, 16'(m));
      chk({cfg.block3_text_select, cfg.block1_text_select, g3, g1}, 16'h0000);
    end
    seq(CMD_FINE_SHIFT, {8'h00});
    chk(cfg.fine_pixel_shift, 16'h0000);
    $display("shift and combine done");
  endtask : t_mode
  task complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    resetn = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    chk(cfg.virtual_width, 16'h0000);
    chk(act, ST_IDLE);
    chk(idx, 16'h0000);
    t_base();
    t_blocks();
    t_mode();
    complete_run();
  end
endmodule : tb_dspl_param_loader
`default_nettype wire
